/* File: rtl/pll_ctrl_pkg.sv */
// Package of field positions, reset values and latch codes for the synthesizer control
package pll_ctrl_pkg;
  localparam int WORD_W = 24;
  // Two low bits of each word pick the target latch
  typedef enum logic [1:0] {
    SEL_REFERENCE = 2'h0,
    SEL_FEEDBACK  = 2'h1,
    SEL_FUNCTION  = 2'h2,
    SEL_INIT      = 2'h3
  } latch_sel_t;
  // Function word fields
  localparam int COUNTER_RESET_POS   = 2;
  localparam int PD_BIT_ONE_POS      = 3;
  localparam int TRISTATE_POS        = 8;
  localparam int FAST_ENABLE_POS     = 9;
  localparam int FAST_MODE_POS       = 10;
  localparam int TIMEOUT_LSB         = 11;
  localparam int TIMEOUT_W           = 4;
  localparam int PRIMARY_CUR_LSB     = 15;
  localparam int SECONDARY_CUR_LSB   = 18;
  localparam int CURRENT_W           = 3;
  localparam int PD_MODE_SELECT_POS  = 21;
  // Feedback word field
  localparam int GAIN_BOOST_POS      = 21;
  // Timeout in charge pump events: 4 * field + 3
  localparam int TIMEOUT_STEP        = 4;
  localparam int TIMEOUT_BASE        = 3;
  localparam int TIMEOUT_CNT_W       = 6;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
endpackage

/* File: rtl/pll_latch_control_sequencer.sv */
// Latch decode, power-down, reset pulse and gain-boost control of the synthesizer
module pll_latch_control_sequencer
  import pll_ctrl_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_input,
  input  wire logic                 load_strobe,
  input  wire logic                 chip_enable,
  input  wire logic                 cp_event,
  output logic                      counters_at_load,
  output logic                      power_down,
  output logic                      lock_detect_reset,
  output logic                      ref_buffer_enable,
  output logic                      charge_pump_tristate,
  output logic                      gain_active,
  output logic [CURRENT_W-1:0]      charge_pump_current,
  output logic [WORD_W-1:0]         reference_word,
  output logic [WORD_W-1:0]         feedback_word,
  output logic [WORD_W-1:0]         function_control_word
);

  // Link domain: serial shift register
  logic [WORD_W-1:0] shift_q;

  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= WORD_RESET;
    end else begin
      shift_q <= {shift_q[WORD_W-2:0], serial_input};
    end
  end

  // Strobe and enable pin synchronisers
  logic le_s1_q;
  logic le_s2_q;
  logic le_s3_q;
  logic ce_s1_q;
  logic ce_s2_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      le_s1_q <= 1'b0;
    end else begin
      le_s1_q <= load_strobe;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      le_s2_q <= 1'b0;
    end else begin
      le_s2_q <= le_s1_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      le_s3_q <= 1'b0;
    end else begin
      le_s3_q <= le_s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ce_s1_q <= 1'b0;
    end else begin
      ce_s1_q <= chip_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ce_s2_q <= 1'b0;
    end else begin
      ce_s2_q <= ce_s1_q;
    end
  end

  // Write strobe for one latch
  function automatic logic latch_hit(input logic       evt,
                                     input latch_sel_t code,
                                     input latch_sel_t target);
    return evt && (code == target);
  endfunction

  // Serial clock is idle while the strobe is high, so the word is stable here
  logic       load_evt;
  latch_sel_t sel;
  assign load_evt = le_s2_q & ~le_s3_q;
  assign sel      = latch_sel_t'(shift_q[1:0]);

  logic wr_ref;
  logic wr_fb;
  logic wr_func;
  logic wr_init;
  assign wr_ref  = latch_hit(load_evt, sel, SEL_REFERENCE);
  assign wr_fb   = latch_hit(load_evt, sel, SEL_FEEDBACK);
  assign wr_func = latch_hit(load_evt, sel, SEL_FUNCTION);
  assign wr_init = latch_hit(load_evt, sel, SEL_INIT);

  // Controls shared by several blocks below
  logic gain;
  logic timed;
  logic gain_clr;
  logic at_load;

  // Latches, never cleared by power-down or the enable pin
  logic [WORD_W-1:0] ref_q;
  logic [WORD_W-1:0] fb_q;
  logic [WORD_W-1:0] func_q;
  logic              armed_q;
  logic              pulse_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= WORD_RESET;
    end else if (wr_ref) begin
      ref_q <= shift_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      func_q <= WORD_RESET;
    end else if (wr_func || wr_init) begin
      func_q <= shift_q;
    end
  end

  // A new feedback word wins over the timed self-clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_q <= WORD_RESET;
    end else if (wr_fb) begin
      fb_q <= shift_q;
    end else if (gain_clr) begin
      fb_q[GAIN_BOOST_POS] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (wr_init) begin
      armed_q <= 1'b1;
    end else if (wr_fb) begin
      armed_q <= 1'b0;
    end
  end

  // Internal reset pulse, one cycle long
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= wr_init | (wr_fb & armed_q);
    end
  end

  // Function fields
  logic cnt_reset_b;
  logic pd_one;
  logic pd_mode;
  logic fast_en;
  logic fast_mode;
  logic tri_bit;
  assign cnt_reset_b = func_q[COUNTER_RESET_POS];
  assign pd_one      = func_q[PD_BIT_ONE_POS];
  assign pd_mode     = func_q[PD_MODE_SELECT_POS];
  assign fast_en     = func_q[FAST_ENABLE_POS];
  assign fast_mode   = func_q[FAST_MODE_POS];
  assign tri_bit     = func_q[TRISTATE_POS];

  // Programmed power-down
  logic pd_q;
  logic pd_pend_q;
  logic pd_d;
  logic pd_pend_d;
  logic pin_pd;
  logic any_pd;
  always_comb begin
    pd_d      = pd_q;
    pd_pend_d = pd_pend_q;
    if (!pd_one) begin
      pd_d      = 1'b0;
      pd_pend_d = 1'b0;
    end else if (!pd_mode) begin
      pd_d      = 1'b1;
      pd_pend_d = 1'b0;
    end else if (!pd_q) begin
      pd_pend_d = 1'b1;
      if (cp_event) begin
        pd_d      = 1'b1;
        pd_pend_d = 1'b0;
      end
    end
    if (pulse_q && ce_s2_q && pd_one && !pd_mode) begin
      pd_d = 1'b1;
    end
  end
  assign pin_pd = ~ce_s2_q;
  assign any_pd = pin_pd | pd_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_pend_q <= 1'b0;
    end else begin
      pd_pend_q <= pd_pend_d;
    end
  end

  // Counter-reset bit never reaches the power-down logic above
  assign at_load = any_pd | pulse_q | cnt_reset_b;

  // Gain boost and timeout
  logic [TIMEOUT_CNT_W-1:0] tmo_q;
  logic [TIMEOUT_CNT_W-1:0] tmo_load;
  logic                     tmo_run_q;
  logic                     tmo_start;

  assign gain  = fb_q[GAIN_BOOST_POS] & fast_en;
  assign timed = fast_en & fast_mode;
  assign tmo_load = TIMEOUT_CNT_W'(func_q[TIMEOUT_LSB +: TIMEOUT_W] * TIMEOUT_STEP
                                   + TIMEOUT_BASE);
  // Gain written while timed-exit is selected starts the timer
  assign tmo_start = wr_fb && shift_q[GAIN_BOOST_POS];
  // Expiry on the last of the counted pump events
  assign gain_clr = timed && tmo_run_q && cp_event && (tmo_q == TIMEOUT_CNT_W'(1))
                    && !at_load;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_q <= '0;
    end else if (at_load || !timed) begin
      tmo_q <= tmo_load;
    end else if (tmo_start) begin
      tmo_q <= tmo_load;
    end else if (tmo_run_q && cp_event && !gain_clr) begin
      tmo_q <= tmo_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_run_q <= 1'b0;
    end else if (at_load || !timed) begin
      tmo_run_q <= 1'b0;
    end else if (tmo_start) begin
      tmo_run_q <= 1'b1;
    end else if (gain_clr) begin
      tmo_run_q <= 1'b0;
    end
  end

  // Pump current selection
  logic [CURRENT_W-1:0] cur_sel;
  assign cur_sel = gain ? func_q[SECONDARY_CUR_LSB +: CURRENT_W]
                        : func_q[PRIMARY_CUR_LSB +: CURRENT_W];

  // Registered outputs, reset shows the powered-down state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      counters_at_load <= 1'b1;
    end else begin
      counters_at_load <= at_load;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_down <= 1'b1;
    end else begin
      power_down <= any_pd;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_detect_reset <= 1'b1;
    end else begin
      lock_detect_reset <= any_pd;
    end
  end

  // Internal pulse leaves the buffer alone
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_buffer_enable <= 1'b0;
    end else begin
      ref_buffer_enable <= ~any_pd;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_pump_tristate <= 1'b1;
    end else begin
      charge_pump_tristate <= tri_bit | at_load;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_active <= 1'b0;
    end else begin
      gain_active <= gain;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_pump_current <= '0;
    end else begin
      charge_pump_current <= cur_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_word <= WORD_RESET;
    end else begin
      reference_word <= ref_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      feedback_word <= WORD_RESET;
    end else begin
      feedback_word <= fb_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      function_control_word <= WORD_RESET;
    end else begin
      function_control_word <= func_q;
    end
  end

endmodule // pll_latch_control_sequencer

/* File: verif/host_model.sv */
// Host model shifting words into the serial port
module host_model (
  output logic serial_clk,
  output logic serial_input,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk   = 1'b0;
    serial_input = 1'b0;
    load_strobe  = 1'b0;
  end
  // Clock runs only inside a word, MSB first
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_input = w[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    serial_input = ~w[0];
    #20 load_strobe = 1'b1;
    #100 load_strobe = 1'b0;
    #200;
  endtask
endmodule // host_model

/* File: verif/pll_ctrl_asserts.sv */
// Concurrent checks on the control sequencer ports
module pll_ctrl_asserts
  import pll_ctrl_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 arst_n,
  input wire logic                 chip_enable,
  input wire logic                 counters_at_load,
  input wire logic                 power_down,
  input wire logic                 lock_detect_reset,
  input wire logic                 ref_buffer_enable,
  input wire logic                 charge_pump_tristate,
  input wire logic                 gain_active,
  input wire logic [CURRENT_W-1:0] charge_pump_current,
  input wire logic [WORD_W-1:0]    function_control_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_PIN_DOWN: assert property (!chip_enable [*4] |-> power_down)
    else $error("pin low without power-down");
  AST_LOCK_RST: assert property (lock_detect_reset == power_down)
    else $error("lock detect reset differs from power-down");
  AST_PD_LOAD: assert property (power_down |-> counters_at_load && charge_pump_tristate)
    else $error("power-down without load state");
  AST_REF_BUF: assert property (ref_buffer_enable == !power_down)
    else $error("reference buffer wrong");
  AST_CRST: assert property ($stable(function_control_word) [*3] ##0
    function_control_word[COUNTER_RESET_POS] |-> counters_at_load && charge_pump_tristate)
    else $error("counter reset not applied");
  AST_TRI: assert property ($stable(function_control_word) [*3] ##0
    function_control_word[TRISTATE_POS] |-> charge_pump_tristate)
    else $error("pump not tri-stated");
  AST_GAIN_EN: assert property ($stable(function_control_word) [*3] ##0
    !function_control_word[FAST_ENABLE_POS] |-> !gain_active)
    else $error("gain active while fast acquire off");
  AST_CUR: assert property ($stable(function_control_word) [*3] |-> charge_pump_current ==
    (gain_active ? function_control_word[20:18] : function_control_word[17:15]))
    else $error("pump current field wrong");
endmodule // pll_ctrl_asserts

bind pll_latch_control_sequencer pll_ctrl_asserts chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .chip_enable(chip_enable), .counters_at_load(counters_at_load), .power_down(power_down),
  .lock_detect_reset(lock_detect_reset), .ref_buffer_enable(ref_buffer_enable),
  .charge_pump_tristate(charge_pump_tristate), .gain_active(gain_active),
  .charge_pump_current(charge_pump_current), .function_control_word(function_control_word));

/* File: verif/testbench.sv */
// Self-checking bench for the latch control sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] FB = 24'h150002;
  logic sys_clk = 1'b0, arst_n, chip_enable, cp_event, sck, sdi, le;
  logic cal, pd, ldr, rbe, tri_q, gain;
  logic [2:0] cur;
  logic [23:0] rw, fw, cw;
  int err_total = 0;
  int num_checks = 0;
  always #10 sys_clk = ~sys_clk;
  host_model host (.serial_clk(sck), .serial_input(sdi), .load_strobe(le));
  pll_latch_control_sequencer DUT (.sys_clk(sys_clk), .arst_n(arst_n), .serial_clk(sck),
    .serial_input(sdi), .load_strobe(le), .chip_enable(chip_enable), .cp_event(cp_event),
    .counters_at_load(cal), .power_down(pd), .lock_detect_reset(ldr),
    .ref_buffer_enable(rbe), .charge_pump_tristate(tri_q), .gain_active(gain),
    .charge_pump_current(cur), .reference_word(rw), .feedback_word(fw),
    .function_control_word(cw));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cp(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      cp_event <= 1'b1;
      @(posedge sys_clk);
      cp_event <= 1'b0;
    end
    cyc(3);
  endtask
  task automatic t_init;
    host.send(FB | 24'h1);
    chk(cw, FB | 24'h1);
    host.send(24'h000104);
    chk(rw, 24'h000104);
    host.send(24'h001201);
    chk(fw, 24'h001201);
    chk({23'h0, cal}, 24'h0);
  endtask
  task automatic t_pin;
    chip_enable <= 1'b0;
    cyc(5);
    chk({22'h0, pd, tri_q}, 24'h3);
    chk({22'h0, ldr, rbe}, 24'h2);
    host.send(24'h000208);
    chk(rw, 24'h000208);
    chip_enable <= 1'b1;
    cyc(5);
    chk({23'h0, pd}, 24'h0);
    chk(fw, 24'h001201);
  endtask
  task automatic t_prog;
    host.send(FB | 24'h8);
    chk({23'h0, pd}, 24'h1);
    host.send(FB);
    host.send(FB | 24'h200008);
    chk({23'h0, pd}, 24'h0);
    cp(1);
    chk({23'h0, pd}, 24'h1);
    host.send(FB);
    chk({23'h0, pd}, 24'h0);
  endtask
  task automatic t_fast;
    host.send(FB | 24'h600);
    host.send(24'h201201);
    chk({20'h0, gain, cur}, 24'hd);
    cp(2);
    chk({23'h0, gain}, 24'h1);
    cp(1);
    chk({20'h0, gain, cur}, 24'h2);
    host.send(FB | 24'h200);
    host.send(24'h201201);
    cp(8);
    chk({23'h0, gain}, 24'h1);
    host.send(24'h001201);
    chk({23'h0, gain}, 24'h0);
    host.send(FB | 24'h400);
    host.send(24'h201201);
    chk({23'h0, gain}, 24'h0);
  endtask
  task automatic t_crst;
    host.send(FB | 24'h4);
    chk({22'h0, cal, pd}, 24'h2);
    host.send(24'h000104);
    host.send(24'h001201);
    chk({22'h0, cal, tri_q}, 24'h3);
    host.send(FB);
    chk({22'h0, cal, tri_q}, 24'h0);
    host.send(FB | 24'h100);
    chk({22'h0, cal, tri_q}, 24'h1);
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    chip_enable = 1'b1;
    cp_event = 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(4);
    t_init;
    t_pin;
    t_prog;
    t_fast;
    t_crst;
    print_verdict;
  end
  initial begin
    #100us;
    err_total++;
    print_verdict;
  end
endmodule // testbench
